// *** include/vsc_consts.svh ***
`ifndef VSC_CONSTS_SVH
`define VSC_CONSTS_SVH
// Contract
// - 720p24 extended reports code 09h
// - 1080p25 extended reports code 0Eh
// - 1080 PsF25 extended: 0Fh, lines 10/572
// - 1080p24 extended reports code 12h
// - 1080 PsF24 extended: 13h, lines 10/572
// - 525i 1440x487 reports 16h, lines 10/276
// - 59.94 and 60 Hz report alike
// - packets inserted into outgoing stream
// - insertion needs SMPTE mode and enable pin
// - per-feature disable bits, reset all zero
// - bit 8 picks horizontal input source
// - HD payload id: luma only, nonzero bytes
// - code in status bits 14:10, resets zero
// - code cleared when bypassed or unlocked
// register offsets
`define VSC_A_DIS 10'h000
`define VSC_A_STAT 10'h004
`define VSC_A_FMTA 10'h00a
`define VSC_A_FMTB 10'h00b
// disable register reset and writable bits
`define VSC_DIS_RST 16'h0000
`define VSC_DIS_WMASK 16'h017f
// field positions
`define VSC_B_HCFG 8
`define VSC_B_PID 6
`define VSC_B_INT 9
`define VSC_STD_HI 14
`define VSC_STD_LO 10
// special codes
`define VSC_UNK_HD 5'h1d
`define VSC_UNK_SD 5'h1e
`define VSC_RSV_A 5'h1c
`define VSC_RSV_B 5'h1f
`define VSC_LAST_720 5'h09
// scan kinds: progressive, interlaced, segmented, any non-progressive
`define VSC_SC_P 2'b00
`define VSC_SC_I 2'b01
`define VSC_SC_S 2'b11
`define VSC_SC_N 2'b10
// payload identifier lines and 525 total width
`define VSC_TOT_525 13'h06b4
`define VSC_PL_10 11'h00a
`define VSC_PL_18 11'h012
`define VSC_PL_572 11'h23c
`define VSC_PL_276 11'h114
`define VSC_PL_9 11'h009
`define VSC_PL_322 11'h142
`define VSC_FIFO_DEPTH 32
`endif

// *** include/vsc_pkg.sv ***
package vsc_pkg;
  // raster description from the detector
  typedef struct packed {
    logic        hd;
    logic [1:0]  scan;
    logic [11:0] act;
    logic [12:0] tot;
    logic [10:0] lines;
  } vsc_raster_t;
  // one table row: code plus match keys
  typedef struct packed {
    logic [4:0]  code;
    vsc_raster_t key;
  } vsc_row_t;
  // one stream word, luma and chroma with insertion slot mark
  typedef struct packed {
    logic [9:0] luma;
    logic [9:0] chroma;
    logic       pid_slot;
  } vsc_word_t;
  // per-feature insertion enables
  typedef struct packed {
    logic h_from_trs;
    logic pid_luma_only;
    logic pid;
    logic remap;
    logic edh;
    logic csum;
    logic crc;
    logic lnum;
    logic trs;
  } vsc_feat_t;
endpackage

// *** hw/vsc_fifo.sv ***
module vsc_fifo #(
  parameter int W     = 21,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];  // storage flops
  logic [AW:0]  wp_r, wp_nxt;  // write pointer with wrap bit
  logic [AW:0]  rp_r, rp_nxt;  // read pointer with wrap bit
  // full when pointers differ only in the wrap bit
  assign in_ready_o  = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign out_valid_o = (wp_r != rp_r);
  assign out_data_o  = mem[rp_r[AW-1:0]];
  // pointer advance
  always_comb begin
    wp_nxt = wp_r + (AW+1)'(in_valid_i && in_ready_o);
    rp_nxt = rp_r + (AW+1)'(out_valid_o && out_ready_i);
  end
  // pointers and storage
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (in_valid_i && in_ready_o) begin
      mem[wp_r[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// *** hw/vsc_top.sv ***
// Added by the designer: the plain strobed port.
`include "vsc_consts.svh"
module vsc_top #(
  parameter int FIFO_DEPTH = `VSC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  // register port
  input  wire logic [9:0]           reg_addr_i,
  input  wire logic [15:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic [15:0]               reg_rdata_o,
  // mode pins
  input  wire logic                 smpte_processing_select_i,
  input  wire logic                 processing_enable_pin_i,
  input  wire logic                 clock_lock_output_i,
  input  wire logic                 hd_mode_i,
  // raster from the detector
  input  wire logic                 raster_valid_i,
  input  wire vsc_pkg::vsc_raster_t raster_i,
  // video stream in
  input  wire logic                 in_valid_i,
  input  wire vsc_pkg::vsc_word_t   in_word_i,
  output logic                      in_ready_o,
  // video stream out
  output logic                      out_valid_o,
  output vsc_pkg::vsc_word_t        out_word_o,
  input  wire logic                 out_ready_i,
  // status and feature enables
  output logic [4:0]                video_std_code_o,
  output logic                      interlace_flag_o,
  output logic [10:0]               pid_line1_o,
  output logic [10:0]               pid_line2_o,
  output vsc_pkg::vsc_feat_t        feat_o
);
  localparam int NROW = 28;
  localparam int WW   = $bits(vsc_pkg::vsc_word_t);
  // standards table, earlier rows win on overlap
  localparam vsc_pkg::vsc_row_t ROWS [NROW] = '{
    '{5'h00, '{1'b1, `VSC_SC_P, 12'h500, 13'h0672, 11'h000}},
    '{5'h01, '{1'b1, `VSC_SC_P, 12'h5a0, 13'h0672, 11'h000}},
    '{5'h02, '{1'b1, `VSC_SC_P, 12'h500, 13'h0ce4, 11'h000}},
    '{5'h03, '{1'b1, `VSC_SC_P, 12'hb40, 13'h0ce4, 11'h000}},
    '{5'h04, '{1'b1, `VSC_SC_P, 12'h500, 13'h07bc, 11'h000}},
    '{5'h05, '{1'b1, `VSC_SC_P, 12'h6c0, 13'h07bc, 11'h000}},
    '{5'h06, '{1'b1, `VSC_SC_P, 12'h500, 13'h0f78, 11'h000}},
    '{5'h07, '{1'b1, `VSC_SC_P, 12'hd80, 13'h0f78, 11'h000}},
    '{5'h08, '{1'b1, `VSC_SC_P, 12'h500, 13'h101d, 11'h000}},
    '{5'h09, '{1'b1, `VSC_SC_P, 12'he10, 13'h101d, 11'h000}},
    '{5'h15, '{1'b1, `VSC_SC_I, 12'h780, 13'h0898, 11'h40b}},
    '{5'h0a, '{1'b1, `VSC_SC_N, 12'h780, 13'h0898, 11'h000}},
    '{5'h0b, '{1'b1, `VSC_SC_P, 12'h780, 13'h0898, 11'h000}},
    '{5'h0c, '{1'b1, `VSC_SC_N, 12'h780, 13'h0a50, 11'h000}},
    '{5'h0d, '{1'b1, `VSC_SC_P, 12'h780, 13'h0a50, 11'h000}},
    '{5'h0e, '{1'b1, `VSC_SC_P, 12'h900, 13'h0a50, 11'h000}},
    '{5'h0f, '{1'b1, `VSC_SC_S, 12'h900, 13'h0a50, 11'h000}},
    '{5'h10, '{1'b1, `VSC_SC_P, 12'h780, 13'h0abe, 11'h000}},
    '{5'h11, '{1'b1, `VSC_SC_S, 12'h780, 13'h0abe, 11'h000}},
    '{5'h12, '{1'b1, `VSC_SC_P, 12'h960, 13'h0abe, 11'h000}},
    '{5'h13, '{1'b1, `VSC_SC_S, 12'h960, 13'h0abe, 11'h000}},
    '{5'h14, '{1'b1, `VSC_SC_I, 12'h780, 13'h0948, 11'h000}},
    '{5'h16, '{1'b0, `VSC_SC_P, 12'h5a0, 13'h06b4, 11'h1e7}},
    '{5'h17, '{1'b0, `VSC_SC_P, 12'h5a0, 13'h06b4, 11'h1fb}},
    '{5'h19, '{1'b0, `VSC_SC_P, 12'h000, 13'h06b4, 11'h1e7}},
    '{5'h1b, '{1'b0, `VSC_SC_P, 12'h000, 13'h06b4, 11'h1fb}},
    '{5'h18, '{1'b0, `VSC_SC_P, 12'h5a0, 13'h06c0, 11'h000}},
    '{5'h1a, '{1'b0, `VSC_SC_P, 12'h000, 13'h06c0, 11'h000}}
  };

  // register state
  logic [15:0]        dis_r, dis_nxt;      // feature disable bits
  logic [15:0]        fmta_r, fmta_nxt;    // payload bytes 1 and 2
  logic [15:0]        fmtb_r, fmtb_nxt;    // payload bytes 3 and 4
  logic [15:0]        rdata_r, rdata_nxt;  // read answer, one cycle only
  // status state
  logic [4:0]         code_r, code_nxt;    // detected standard code
  logic               intl_r, intl_nxt;    // interlace flag
  logic [10:0]        pl1_r, pl1_nxt;      // first payload id line
  logic [10:0]        pl2_r, pl2_nxt;      // second payload id line
  // lookup results
  logic [NROW-1:0]    hit;                 // per-row match
  logic [4:0]         lk_code;             // chosen code
  logic [10:0]        lk_l1;               // chosen first line
  logic [10:0]        lk_l2;               // chosen second line
  // stream state
  logic               f_valid;             // fifo has a word
  vsc_pkg::vsc_word_t f_word;              // fifo head
  logic               f_ready;             // output stage can take
  logic               ov_r, ov_nxt;        // output word valid
  vsc_pkg::vsc_word_t ow_r, ow_nxt;        // output word
  logic [1:0]         bidx_r, bidx_nxt;    // payload byte index
  logic [7:0]         pbyte;               // current payload byte
  logic               proc_on;             // select and enable pins both high
  logic               std_on;              // standard may be reported

  assign proc_on = smpte_processing_select_i && processing_enable_pin_i;
  assign std_on  = smpte_processing_select_i && clock_lock_output_i;

  // per-row compare; zero active or lines means either count is fine
  // row matching
  for (genvar g = 0; g < NROW; g++) begin : g_row
    assign hit[g] = (ROWS[g].key.hd == raster_i.hd)
                 && (ROWS[g].key.tot == raster_i.tot)
                 && (ROWS[g].key.act == 12'h000 || ROWS[g].key.act == raster_i.act)
                 && (ROWS[g].key.lines == 11'h000 || ROWS[g].key.lines == raster_i.lines)
                 && (!raster_i.hd || ROWS[g].key.scan == raster_i.scan
                     || (ROWS[g].key.scan == `VSC_SC_N && raster_i.scan != `VSC_SC_P));
  end

  // pick first matching row, then its payload id lines
  // frame rate is no key, so 59.94 and 60 Hz give one code
  always_comb begin
    lk_code = raster_i.hd ? `VSC_UNK_HD : `VSC_UNK_SD;
    for (int i = NROW - 1; i >= 0; i--) begin
      if (hit[i]) begin
        lk_code = ROWS[i].code;
      end
    end
    lk_l1 = 11'h000;
    lk_l2 = 11'h000;
    if (lk_code == `VSC_UNK_HD || lk_code == `VSC_UNK_SD) begin
      // unknown raster carries no lines
      lk_l1 = 11'h000;
    end else if (lk_code <= `VSC_LAST_720) begin
      lk_l1 = `VSC_PL_10;
    end else if (raster_i.hd && raster_i.scan == `VSC_SC_P) begin
      lk_l1 = `VSC_PL_18;
    end else if (raster_i.hd) begin
      lk_l1 = `VSC_PL_10;
      lk_l2 = `VSC_PL_572;
    end else if (raster_i.tot == `VSC_TOT_525) begin
      lk_l1 = `VSC_PL_10;
      lk_l2 = `VSC_PL_276;
    end else begin
      lk_l1 = `VSC_PL_9;
      lk_l2 = `VSC_PL_322;
    end
  end

  // status next values
  always_comb begin
    code_nxt = code_r;
    intl_nxt = intl_r;
    pl1_nxt  = pl1_r;
    pl2_nxt  = pl2_r;
    if (!std_on) begin
      code_nxt = 5'h00;
      intl_nxt = 1'b0;
      pl1_nxt  = 11'h000;
      pl2_nxt  = 11'h000;
    end else if (raster_valid_i) begin
      // segmented frames report as interlaced, as they travel in fields
      code_nxt = lk_code;
      intl_nxt = raster_i.scan != `VSC_SC_P;
      pl1_nxt  = lk_l1;
      pl2_nxt  = lk_l2;
    end
  end

  // status registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      code_r <= 5'h00;
      intl_r <= 1'b0;
      pl1_r  <= 11'h000;
      pl2_r  <= 11'h000;
    end else begin
      code_r <= code_nxt;
      intl_r <= intl_nxt;
      pl1_r  <= pl1_nxt;
      pl2_r  <= pl2_nxt;
    end
  end

  // register port: write decode and one-cycle read answer
  always_comb begin
    dis_nxt   = dis_r;
    fmta_nxt  = fmta_r;
    fmtb_nxt  = fmtb_r;
    rdata_nxt = 16'h0000;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `VSC_A_DIS:  dis_nxt  = reg_wdata_i & `VSC_DIS_WMASK;
        `VSC_A_FMTA: fmta_nxt = reg_wdata_i;
        `VSC_A_FMTB: fmtb_nxt = reg_wdata_i;
        // status and unmapped writes are dropped
        default:     dis_nxt  = dis_r;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `VSC_A_DIS:  rdata_nxt = dis_r;
        `VSC_A_STAT: begin
          rdata_nxt[`VSC_STD_HI:`VSC_STD_LO] = code_r;
          rdata_nxt[`VSC_B_INT]              = intl_r;
        end
        `VSC_A_FMTA: rdata_nxt = fmta_r;
        `VSC_A_FMTB: rdata_nxt = fmtb_r;
        // unmapped reads answer zero
        default:     rdata_nxt = 16'h0000;
      endcase
    end
  end

  // register state
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dis_r   <= `VSC_DIS_RST;
      fmta_r  <= 16'h0000;
      fmtb_r  <= 16'h0000;
      rdata_r <= 16'h0000;
    end else begin
      dis_r   <= dis_nxt;
      fmta_r  <= fmta_nxt;
      fmtb_r  <= fmtb_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // feature enables for the insertion engines downstream
  always_comb begin
    feat_o.trs   = proc_on && !dis_r[0];
    feat_o.lnum  = proc_on && !dis_r[1];
    feat_o.crc   = proc_on && !dis_r[2];
    feat_o.csum  = proc_on && !dis_r[3];
    feat_o.edh   = proc_on && !dis_r[4];
    feat_o.remap = proc_on && !dis_r[5];
    feat_o.pid   = proc_on && hd_mode_i && !dis_r[`VSC_B_PID]
                && ((fmta_r != 16'h0000) || (fmtb_r != 16'h0000));
    feat_o.pid_luma_only = hd_mode_i;
    feat_o.h_from_trs    = dis_r[`VSC_B_HCFG];
  end

  // the fifo decouples the source from output back-pressure
  vsc_fifo #(
    .W     (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .in_valid_i  (in_valid_i),
    .in_data_i   (in_word_i),
    .in_ready_o  (in_ready_o),
    .out_valid_o (f_valid),
    .out_data_o  (f_word),
    .out_ready_i (f_ready)
  );

  // output stage takes a word when empty or being drained
  assign f_ready = !ov_r || out_ready_i;
  // bytes go out in order 1..4, byte 1 in the low half of the first register
  assign pbyte   = bidx_r[1] ? (bidx_r[0] ? fmtb_r[15:8] : fmtb_r[7:0])
                             : (bidx_r[0] ? fmta_r[15:8] : fmta_r[7:0]);

  // insertion of payload id words into marked luma slots
  always_comb begin
    ov_nxt   = ov_r;
    ow_nxt   = ow_r;
    bidx_nxt = bidx_r;
    if (f_ready) begin
      ov_nxt = f_valid;
      if (f_valid) begin
        ow_nxt = f_word;
        if (f_word.pid_slot && feat_o.pid) begin
          ow_nxt.luma = {~(^pbyte), ^pbyte, pbyte};
          bidx_nxt    = bidx_r + 2'b01;
        end else if (!f_word.pid_slot) begin
          // a gap restarts the byte sequence
          bidx_nxt = 2'b00;
        end
      end
    end
  end

  // output stage registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ov_r   <= 1'b0;
      ow_r   <= '0;
      bidx_r <= 2'b00;
    end else begin
      ov_r   <= ov_nxt;
      ow_r   <= ow_nxt;
      bidx_r <= bidx_nxt;
    end
  end

  // outputs
  assign reg_rdata_o      = rdata_r;
  assign out_valid_o      = ov_r;
  assign out_word_o       = ow_r;
  assign video_std_code_o = code_r;
  assign interlace_flag_o = intl_r;
  assign pid_line1_o      = pl1_r;
  assign pid_line2_o      = pl2_r;

  // checks
  property p_dis_wr;
    @(posedge clock_i) disable iff (srst_i)
      (reg_wr_i && reg_addr_i == `VSC_A_DIS) |=>
        (dis_r == ($past(reg_wdata_i) & `VSC_DIS_WMASK));
  endproperty
  a_dis_wr: assert property (p_dis_wr) else $error("disable register write lost");
  property p_std_clr;
    @(posedge clock_i) disable iff (srst_i)
      !std_on |=> (code_r == 5'h00 && !intl_r);
  endproperty
  a_std_clr: assert property (p_std_clr) else $error("code kept while bypassed");
  property p_stat_rd;
    @(posedge clock_i) disable iff (srst_i)
      (reg_rd_i && reg_addr_i == `VSC_A_STAT) |=>
        (reg_rdata_o[`VSC_STD_HI:`VSC_STD_LO] == $past(code_r)) ##1 (reg_rdata_o == 16'h0000
        || $past(reg_rd_i));
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read answer wrong");
  property p_no_rsv;
    @(posedge clock_i) disable iff (srst_i)
      code_r != `VSC_RSV_A && code_r != `VSC_RSV_B;
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved code reported");
  property p_gate;
    @(posedge clock_i) disable iff (srst_i)
      (feat_o.trs || feat_o.pid) |-> (smpte_processing_select_i && processing_enable_pin_i);
  endproperty
  a_gate: assert property (p_gate) else $error("insertion without mode pins");
  property p_pid_en;
    @(posedge clock_i) disable iff (srst_i)
      feat_o.pid |-> (hd_mode_i && !dis_r[`VSC_B_PID] && (fmta_r | fmtb_r) != 16'h0000);
  endproperty
  a_pid_en: assert property (p_pid_en) else $error("payload id enabled wrongly");
  property p_hcfg;
    @(posedge clock_i) disable iff (srst_i)
      (reg_wr_i && reg_addr_i == `VSC_A_DIS) |=> (feat_o.h_from_trs == $past(reg_wdata_i[8]));
  endproperty
  a_hcfg: assert property (p_hcfg) else $error("horizontal source not followed");
  property p_720em;
    @(posedge clock_i) disable iff (srst_i)
      (std_on && raster_valid_i && raster_i.hd && raster_i.act == 12'he10
       && raster_i.tot == 13'h101d && raster_i.scan == `VSC_SC_P) |=> (code_r == 5'h09);
  endproperty
  a_720em: assert property (p_720em) else $error("720p24 extended code wrong");
endmodule

// *** tb/vsc_tb_sink.sv ***
module vsc_tb_sink (
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               srst_i,
  // stream from the block
  input  wire logic               valid_i,
  input  wire vsc_pkg::vsc_word_t word_i,
  output logic                    ready_o,
  // pacing set by the bench
  input  wire logic               stall_i,
  input  wire logic               slow_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // words taken, in arrival order
  vsc_pkg::vsc_word_t got[$];
  // a slow sink drops ready every other cycle to exercise hold
  always @(posedge clock_i) begin
    if (srst_i) begin
      ready_o <= 1'b0;
    end else begin
      if (valid_i && ready_o) begin
        got.push_back(word_i);
      end
      ready_o <= !stall_i && !(slow_i && ready_o);
    end
  end
endmodule

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 32;
  // one raster and the status it should give
  typedef struct packed {
    vsc_pkg::vsc_raster_t r;
    logic [4:0]           code;
    logic [10:0]          l1;
    logic [10:0]          l2;
    logic                 intl;
    logic                 full;  // low: lines and flag pins go unchecked
  } vsc_tb_row_t;
  logic clock_i, srst_i, reg_wr_i, reg_rd_i, smpte_i, pen_i, lock_i, hd_i;
  logic raster_valid_i, in_valid_i, in_ready_o, out_valid_o, out_ready_i;
  logic stall, slow, intl_o;
  logic [9:0]           reg_addr_i;
  logic [15:0]          reg_wdata_i, reg_rdata_o;
  logic [4:0]           code_o;
  logic [10:0]          l1_o, l2_o;
  vsc_pkg::vsc_raster_t raster_i;
  vsc_pkg::vsc_word_t   in_word_i, out_word_o;
  vsc_pkg::vsc_feat_t   feat_o;
  vsc_pkg::vsc_word_t   tx[$];
  vsc_tb_row_t          rows[11];
  int errors = 0;
  int cmp_count = 0;
  int n;
  vsc_top #(.FIFO_DEPTH(DEPTH)) dut (
    .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .smpte_processing_select_i(smpte_i),
    .processing_enable_pin_i(pen_i), .clock_lock_output_i(lock_i), .hd_mode_i(hd_i),
    .raster_valid_i(raster_valid_i), .raster_i(raster_i), .in_valid_i(in_valid_i),
    .in_word_i(in_word_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
    .out_word_o(out_word_o), .out_ready_i(out_ready_i), .video_std_code_o(code_o),
    .interlace_flag_o(intl_o), .pid_line1_o(l1_o), .pid_line2_o(l2_o), .feat_o(feat_o));
  vsc_tb_sink partner (
    .clock_i(clock_i), .srst_i(srst_i), .valid_i(out_valid_o), .word_i(out_word_o),
    .ready_o(out_ready_i), .stall_i(stall), .slow_i(slow));
  // 4 ns clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  // strobes stay up between back-to-back accesses; idle drops them
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk(reg_rdata_o === e, "register read mismatch");
  endtask
  task automatic idle();
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // pushes tx with valid held; cnt tells how many were taken
  task automatic send(output int cnt, input int lim);
    int t;
    t = 0;
    cnt = 0;
    in_valid_i <= 1'b1;
    in_word_i <= tx[0];
    while (cnt < tx.size() && t < lim) begin
      @(posedge clock_i);
      t++;
      if (in_ready_o === 1'b1) begin
        cnt++;
        if (cnt < tx.size()) in_word_i <= tx[cnt];
      end
    end
    in_valid_i <= 1'b0;
  endtask
  task automatic wait_got(input int want);
    for (int t = 0; t < 2000 && partner.got.size() < want; t++) @(posedge clock_i);
    // let the sink's push and the edge's updates settle first
    #1;
    chk(partner.got.size() == want, "word count at sink");
  endtask
  // coded payload byte in luma: inverse parity, even parity, byte
  function automatic logic [9:0] enc(input logic [7:0] b);
    return {~(^b), ^b, b};
  endfunction
  task automatic results();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // cut a hang short well past the expected run
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    $display("Error %0t: watchdog expired", $time);
    results();
  end
  initial begin
    srst_i = 1'b1;
    {reg_wr_i, reg_rd_i, raster_valid_i, in_valid_i, stall, slow} = '0;
    {smpte_i, pen_i, lock_i, hd_i} = 4'hf;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    raster_i = '0;
    in_word_i = '0;
    rows = '{
      '{'{1'b1, 2'b00, 12'he10, 13'h101d, 11'h2d0}, 5'h09, 11'h00a, 11'h000, 1'b0, 1'b1},
      '{'{1'b1, 2'b00, 12'h900, 13'h0a50, 11'h438}, 5'h0e, 11'h012, 11'h000, 1'b0, 1'b1},
      '{'{1'b1, 2'b11, 12'h900, 13'h0a50, 11'h438}, 5'h0f, 11'h00a, 11'h23c, 1'b1, 1'b1},
      '{'{1'b1, 2'b00, 12'h960, 13'h0abe, 11'h438}, 5'h12, 11'h012, 11'h000, 1'b0, 1'b1},
      '{'{1'b1, 2'b11, 12'h960, 13'h0abe, 11'h438}, 5'h13, 11'h00a, 11'h23c, 1'b1, 1'b1},
      '{'{1'b1, 2'b00, 12'h500, 13'h101d, 11'h2d0}, 5'h08, 11'h00a, 11'h000, 1'b0, 1'b1},
      '{'{1'b0, 2'b01, 12'h5a0, 13'h06c0, 11'h240}, 5'h18, 11'h009, 11'h142, 1'b1, 1'b1},
      '{'{1'b0, 2'b01, 12'h3e8, 13'h06b4, 11'h1e7}, 5'h19, 11'h00a, 11'h114, 1'b1, 1'b1},
      '{'{1'b1, 2'b00, 12'h064, 13'h00c8, 11'h438}, 5'h1d, 11'h000, 11'h000, 1'b0, 1'b0},
      '{'{1'b0, 2'b01, 12'h5a0, 13'h06b4, 11'h12c}, 5'h1e, 11'h000, 11'h000, 1'b1, 1'b0},
      '{'{1'b0, 2'b01, 12'h5a0, 13'h06b4, 11'h1e7}, 5'h16, 11'h00a, 11'h114, 1'b1, 1'b1}};
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(10'h000, 16'h0000);
    rd(10'h004, 16'h0000);
    // table of rasters, status on pins and through the register
    for (int i = 0; i < 11; i++) begin
      // the last read strobe lasts one cycle only
      reg_rd_i <= 1'b0;
      raster_i <= rows[i].r;
      raster_valid_i <= 1'b1;
      @(posedge clock_i);
      #1;
      chk(code_o === rows[i].code, "std code");
      if (rows[i].full) begin
        chk({l1_o, l2_o, intl_o} === {rows[i].l1, rows[i].l2, rows[i].intl}, "lines");
      end
      rd(10'h004, {1'b0, rows[i].code, rows[i].intl, 9'h000});
    end
    raster_valid_i <= 1'b0;
    idle();
    // writes to status and unmapped places change nothing
    wr(10'h004, 16'hffff);
    wr(10'h3ff, 16'hffff);
    rd(10'h004, {1'b0, 5'h16, 1'b1, 9'h000});
    rd(10'h3ff, 16'h0000);
    // losing lock clears status in one cycle
    lock_i <= 1'b0;
    idle();
    #1;
    chk({code_o, intl_o, l1_o} === '0, "status after unlock");
    lock_i <= 1'b1;
    // payload bytes 1..4 = 03 05 80 0f, then feature enables
    wr(10'h00a, 16'h0503);
    wr(10'h00b, 16'h0f80);
    rd(10'h000, 16'h0000);
    chk(feat_o === 9'h0ff, "all features on");
    for (int b = 0; b < 7; b++) begin
      wr(10'h000, 16'h0001 << b);
      #1;
      // luma-only stays up in hd mode whatever the disable bits
      chk(feat_o[7:0] === ~(8'h01 << b), "one feature off");
    end
    wr(10'h000, 16'hffff);
    rd(10'h000, 16'h017f);
    chk(feat_o === 9'h180, "h from timing words");
    wr(10'h000, 16'h0000);
    pen_i <= 1'b0;
    idle();
    chk(feat_o[6:0] === 7'h00, "enable pin low");
    pen_i <= 1'b1;
    smpte_i <= 1'b0;
    hd_i <= 1'b0;
    idle();
    chk(feat_o[7:0] === 8'h00, "bypass");
    smpte_i <= 1'b1;
    idle();
    // outside hd mode neither luma-only nor payload id insertion is on
    chk(feat_o[7:0] === 8'h3f, "luma-only needs hd");
    hd_i <= 1'b1;
    // payload slots: six, one plain word, one more slot
    for (int i = 0; i < 8; i++) tx.push_back({10'h040 + 10'(i), 10'h200 + 10'(i), i != 6});
    slow <= 1'b1;
    send(n, 200);
    wait_got(8);
    foreach (partner.got[i]) begin
      chk(partner.got[i].chroma === tx[i].chroma, "chroma untouched");
    end
    chk(partner.got[0].luma === enc(8'h03), "byte 1");
    chk(partner.got[3].luma === enc(8'h0f), "byte 4");
    chk(partner.got[4].luma === enc(8'h03), "wraps to byte 1");
    chk(partner.got[5].luma === enc(8'h05), "byte 2");
    chk(partner.got[6].luma === tx[6].luma, "plain word");
    chk(partner.got[7].luma === enc(8'h03), "restart at byte 1");
    // fill until refused while the sink stalls, then drain slowly
    partner.got.delete();
    tx.delete();
    for (int i = 0; i < 40; i++) tx.push_back({10'h100 + 10'(i), 10'h000, 1'b0});
    stall <= 1'b1;
    send(n, 80);
    chk(n == DEPTH + 1, "words taken before refusal");
    stall <= 1'b0;
    wait_got(DEPTH + 1);
    foreach (partner.got[i]) begin
      chk(partner.got[i].luma === tx[i].luma, "drain order");
    end
    chk({out_valid_o, in_ready_o} === 2'b01, "empty after drain");
    // reset in mid-run clears the register and the status
    raster_i <= rows[0].r;
    raster_valid_i <= 1'b1;
    wr(10'h000, 16'h0100);
    #1;
    chk({code_o, feat_o[8]} === {5'h09, 1'b1}, "state before reset");
    raster_valid_i <= 1'b0;
    srst_i <= 1'b1;
    idle();
    srst_i <= 1'b0;
    rd(10'h000, 16'h0000);
    chk({code_o, feat_o[8]} === 6'h00, "state after reset");
    idle();
    results();
  end
endmodule
